// [common/aal_pkg.sv]
// Package for the accumulator datapath: offsets, fields, codes, types
package aal_pkg;

	// Register byte offsets
	localparam logic [7:0] OFS_ACC    = 8'h00;
	localparam logic [7:0] OFS_FLAGS  = 8'h04;
	localparam logic [7:0] OFS_OPND   = 8'h08;
	localparam logic [7:0] OFS_CMD    = 8'h0c;
	localparam logic [7:0] OFS_RESULT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_SECOND = 8'hf0;

	// Reset values
	localparam logic [7:0] ACC_RST    = 8'h00;
	localparam logic [7:0] SECOND_RST = 8'h00;
	localparam logic [7:0] BYTE_ZERO  = 8'h00;

	// Flag bit positions in the flag register
	localparam int CY_POS = 7;
	localparam int HC_POS = 6;
	localparam int RE_POS = 2;

	// Status bit positions
	localparam int BUSY_POS  = 0;
	localparam int DZERO_POS = 1;

	// Operand register fields
	localparam int RAM_LSB = 0;
	localparam int IMM_LSB = 8;

	// Product threshold for the range exceed flag
	localparam logic [15:0] PROD_LIMIT = 16'h00ff;

	// Divide iterations
	localparam logic [2:0] DIV_LAST = 3'h7;

	// Operation codes
	typedef enum logic [3:0] {
		OP_NOP      = 4'h0,
		OP_PRODUCT  = 4'h1,
		OP_QUOTIENT = 4'h2,
		OP_RR       = 4'h3,
		OP_RRC      = 4'h4,
		OP_RL       = 4'h5,
		OP_RLC      = 4'h6,
		OP_AND      = 4'h7,
		OP_OR       = 4'h8,
		OP_XOR      = 4'h9,
		OP_CAND     = 4'ha,
		OP_CANDN    = 4'hb,
		OP_COR      = 4'hc,
		OP_CORN     = 4'hd
	} aal_op_t;

	// Command word layout
	typedef struct packed {
		logic [20:0] pad;
		logic [2:0]  bit_sel;
		logic [1:0]  pad2;
		logic        src_imm;
		logic        dst_ram;
		aal_op_t     op;
	} aal_cmd_t;

	// Captured AHB address phase
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [7:0] addr;
	} aal_aphase_t;

	// Divider states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_DIV  = 2'b01
	} aal_state_t;

endpackage : aal_pkg

// [hw/aal_datapath.sv]
// Accumulator ALU: product, quotient, rotates, byte and carry logic
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps

// Contract
// - Product: low byte to acc, high byte second
// - Product sets range flag above 255, clears carry
// - Quotient to acc, remainder to second register
// - Quotient clears carry and range; zero divisor sets range
// - Rotate right, bit 0 into bit 7
// - Rotate right through carry
// - Rotate left, bit 7 into bit 0
// - Rotate left through carry
// - Bytewise AND into first operand
// - Bytewise OR into first operand
// - Bytewise XOR into first operand
// - Destination acc or RAM; source acc or immediate
// - Carry AND with bit
// - Carry AND with complemented bit
// - Carry OR with bit
// - Carry OR with complemented bit
// - Source bit untouched, only carry written
// - No carry XOR with a bit
// - Second operand register at F0
module aal_datapath (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp
);

	// Bytewise logic on two bytes
	function automatic logic [7:0] byte_logic(
		input aal_pkg::aal_op_t op,
		input logic [7:0]       a,
		input logic [7:0]       b
	);
		logic [7:0] r;
		r = a;
		case (op)
			aal_pkg::OP_AND: r = a & b;
			aal_pkg::OP_OR:  r = a | b;
			aal_pkg::OP_XOR: r = a ^ b;
			default:         r = a;
		endcase
		return r;
	endfunction : byte_logic

	// Carry Boolean with one bit
	function automatic logic carry_logic(
		input aal_pkg::aal_op_t op,
		input logic             c,
		input logic             b
	);
		logic r;
		r = c;
		case (op)
			aal_pkg::OP_CAND:  r = c & b;
			aal_pkg::OP_CANDN: r = c & ~b;
			aal_pkg::OP_COR:   r = c | b;
			aal_pkg::OP_CORN:  r = c | ~b;
			default:           r = c;
		endcase
		return r;
	endfunction : carry_logic

	// Architectural registers
	logic [7:0]            acc_reg;          // Main work register
	logic [7:0]            second_reg;       // Second operand register
	logic                  cy_reg;           // Carry flag
	logic                  hc_reg;           // Half carry flag
	logic                  re_reg;           // Range exceed flag
	logic [15:0]           opnd_reg;         // RAM byte and immediate
	logic [7:0]            result_reg;       // RAM destination result
	logic                  dzero_reg;        // Last divide was by zero
	// Bus state
	aal_pkg::aal_aphase_t  aph_reg;          // Pending data phase
	logic                  rd_wait_reg;      // Read wait state
	logic [31:0]           hrdata_reg;       // Read data
	// Divider state
	aal_pkg::aal_state_t   state_reg;        // Divider state
	logic [2:0]            cnt_reg;          // Iteration count
	logic [7:0]            rem_reg;          // Partial remainder
	logic [7:0]            quo_reg;          // Shifting quotient
	logic [7:0]            dsr_reg;          // Latched divisor

	// Decoded command
	aal_pkg::aal_cmd_t     cmd;              // Command word view
	logic                  cmd_wr;           // Command write strobe
	logic                  start;            // Accepted command
	logic                  busy;             // Divide in progress
	logic [7:0]            ram_byte;         // RAM operand
	logic [7:0]            imm_byte;         // Immediate operand
	logic [7:0]            first_opnd;       // Destination value
	logic [7:0]            second_opnd;      // Source value
	logic [7:0]            logic_res;        // Bytewise result
	logic                  addr_bit;         // Addressed bit
	logic [15:0]           product;          // Full product
	logic [8:0]            trial;            // Trial subtraction
	logic                  div_end;          // Last divide step
	logic                  wr_acc;           // Bus write to acc
	logic                  wr_second;        // Bus write to second
	logic                  wr_flags;         // Bus write to flags
	logic                  wr_opnd;          // Bus write to operand
	logic                  aph_take;         // Address phase taken

	// Address phase qualification
	assign aph_take = hsel & hready & htrans[1];

	// Write strobes in the data phase
	always_comb
	begin
		wr_acc    = 1'b0;
		wr_second = 1'b0;
		wr_flags  = 1'b0;
		wr_opnd   = 1'b0;
		cmd_wr    = 1'b0;
		if (aph_reg.valid && aph_reg.write)
		begin
			case (aph_reg.addr)
				aal_pkg::OFS_ACC:    wr_acc    = 1'b1;
				aal_pkg::OFS_SECOND: wr_second = 1'b1;
				aal_pkg::OFS_FLAGS:  wr_flags  = 1'b1;
				aal_pkg::OFS_OPND:   wr_opnd   = 1'b1;
				aal_pkg::OFS_CMD:    cmd_wr    = 1'b1;
				// Unmapped writes are dropped
				default:             cmd_wr    = 1'b0;
			endcase
		end
	end

	// Operand selection
	assign cmd      = aal_pkg::aal_cmd_t'(hwdata);
	assign busy     = (state_reg == aal_pkg::ST_DIV);
	// Commands while dividing are ignored
	assign start    = cmd_wr & ~busy;
	assign ram_byte = opnd_reg[aal_pkg::RAM_LSB +: 8];
	assign imm_byte = opnd_reg[aal_pkg::IMM_LSB +: 8];
	assign first_opnd  = cmd.dst_ram ? ram_byte : acc_reg;
	assign second_opnd = cmd.src_imm ? imm_byte : acc_reg;
	assign logic_res   = byte_logic(cmd.op, first_opnd, second_opnd);
	assign addr_bit    = ram_byte[cmd.bit_sel];
	// Operands widened first so the upper product byte is kept
	assign product     = {8'h00, acc_reg} * {8'h00, second_reg};
	assign trial       = {rem_reg, quo_reg[7]} - {1'b0, dsr_reg};
	assign div_end     = busy && (cnt_reg == aal_pkg::DIV_LAST);

	// Address phase capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			aph_reg <= '0;
		else if (hready)
		begin
			aph_reg.valid <= aph_take;
			aph_reg.write <= hwrite;
			aph_reg.addr  <= haddr[7:0];
		end
		else
			aph_reg.valid <= aph_reg.valid & ~rd_wait_reg;
	end

	// One wait state on reads so data is from flops
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			rd_wait_reg <= 1'b0;
		else
			rd_wait_reg <= aph_take & ~hwrite;
	end

	// Read mux captured in the wait state
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= '0;
		else if (rd_wait_reg)
		begin
			case (aph_reg.addr)
				aal_pkg::OFS_ACC:    hrdata_reg <= {24'h0, acc_reg};
				aal_pkg::OFS_SECOND: hrdata_reg <= {24'h0, second_reg};
				aal_pkg::OFS_FLAGS:
				begin
					hrdata_reg <= '0;
					hrdata_reg[aal_pkg::CY_POS] <= cy_reg;
					hrdata_reg[aal_pkg::HC_POS] <= hc_reg;
					hrdata_reg[aal_pkg::RE_POS] <= re_reg;
				end
				aal_pkg::OFS_OPND:   hrdata_reg <= {16'h0, opnd_reg};
				aal_pkg::OFS_RESULT: hrdata_reg <= {24'h0, result_reg};
				aal_pkg::OFS_STATUS:
				begin
					hrdata_reg <= '0;
					hrdata_reg[aal_pkg::BUSY_POS]  <= busy;
					hrdata_reg[aal_pkg::DZERO_POS] <= dzero_reg;
				end
				// Unmapped reads return zero
				default:             hrdata_reg <= '0;
			endcase
		end
	end

	// Bus outputs
	assign hrdata    = hrdata_reg;
	assign hreadyout = ~rd_wait_reg;
	assign hresp     = 1'b0;

	// Operand register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			opnd_reg <= '0;
		else if (wr_opnd)
			opnd_reg <= hwdata[15:0];
	end

	// Main work register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			acc_reg <= aal_pkg::ACC_RST;
		else if (div_end)
			acc_reg <= {quo_reg[6:0], ~trial[8]};
		else if (start)
		begin
			case (cmd.op)
				aal_pkg::OP_PRODUCT: acc_reg <= product[7:0];
				aal_pkg::OP_RR:  acc_reg <= {acc_reg[0], acc_reg[7:1]};
				aal_pkg::OP_RRC: acc_reg <= {cy_reg, acc_reg[7:1]};
				aal_pkg::OP_RL:  acc_reg <= {acc_reg[6:0], acc_reg[7]};
				aal_pkg::OP_RLC: acc_reg <= {acc_reg[6:0], cy_reg};
				aal_pkg::OP_AND, aal_pkg::OP_OR, aal_pkg::OP_XOR:
				begin
					if (!cmd.dst_ram)
						acc_reg <= logic_res;
				end
				default: acc_reg <= acc_reg;
			endcase
		end
		else if (wr_acc)
			acc_reg <= hwdata[7:0];
	end

	// Second operand register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			second_reg <= aal_pkg::SECOND_RST;
		else if (div_end)
			second_reg <= trial[8] ? {rem_reg[6:0], quo_reg[7]}
			                       : trial[7:0];
		else if (start && cmd.op == aal_pkg::OP_PRODUCT)
			second_reg <= product[15:8];
		else if (wr_second)
			second_reg <= hwdata[7:0];
	end

	// RAM destination result
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			result_reg <= aal_pkg::BYTE_ZERO;
		else if (start && cmd.dst_ram)
		begin
			case (cmd.op)
				aal_pkg::OP_AND, aal_pkg::OP_OR, aal_pkg::OP_XOR:
					result_reg <= logic_res;
				default: result_reg <= result_reg;
			endcase
		end
	end

	// Carry flag; operations win over software writes
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cy_reg <= 1'b0;
		else if (div_end)
			cy_reg <= 1'b0;
		else if (start)
		begin
			case (cmd.op)
				aal_pkg::OP_PRODUCT, aal_pkg::OP_QUOTIENT:
					cy_reg <= 1'b0;
				aal_pkg::OP_RRC: cy_reg <= acc_reg[0];
				aal_pkg::OP_RLC: cy_reg <= acc_reg[7];
				aal_pkg::OP_CAND, aal_pkg::OP_CANDN,
				aal_pkg::OP_COR, aal_pkg::OP_CORN:
					cy_reg <= carry_logic(cmd.op, cy_reg, addr_bit);
				// No carry XOR; others keep carry
				default: cy_reg <= cy_reg;
			endcase
		end
		else if (wr_flags)
			cy_reg <= hwdata[aal_pkg::CY_POS];
	end

	// Range exceed flag
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			re_reg <= 1'b0;
		else if (div_end)
			re_reg <= 1'b0;
		else if (start)
		begin
			case (cmd.op)
				aal_pkg::OP_PRODUCT:
					re_reg <= (product > aal_pkg::PROD_LIMIT);
				aal_pkg::OP_QUOTIENT:
					re_reg <= (second_reg == aal_pkg::BYTE_ZERO);
				default: re_reg <= re_reg;
			endcase
		end
		else if (wr_flags)
			re_reg <= hwdata[aal_pkg::RE_POS];
	end

	// Half carry flag; no operation here alters it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hc_reg <= 1'b0;
		else if (wr_flags && !start && !div_end)
			hc_reg <= hwdata[aal_pkg::HC_POS];
	end

	// Divide-by-zero status
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dzero_reg <= 1'b0;
		else if (start && cmd.op == aal_pkg::OP_QUOTIENT)
			dzero_reg <= (second_reg == aal_pkg::BYTE_ZERO);
	end

	// Divider sequencer, one quotient bit per cycle
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_reg <= aal_pkg::ST_IDLE;
			cnt_reg   <= '0;
			rem_reg   <= '0;
			quo_reg   <= '0;
			dsr_reg   <= '0;
		end
		else
		begin
			case (state_reg)
				aal_pkg::ST_IDLE:
				begin
					if (start && cmd.op == aal_pkg::OP_QUOTIENT
					    && second_reg != aal_pkg::BYTE_ZERO)
					begin
						state_reg <= aal_pkg::ST_DIV;
						cnt_reg   <= '0;
						rem_reg   <= '0;
						quo_reg   <= acc_reg;
						dsr_reg   <= second_reg;
					end
				end
				aal_pkg::ST_DIV:
				begin
					rem_reg <= trial[8] ? {rem_reg[6:0], quo_reg[7]}
					                    : trial[7:0];
					quo_reg <= {quo_reg[6:0], ~trial[8]};
					cnt_reg <= cnt_reg + 3'h1;
					if (div_end)
						state_reg <= aal_pkg::ST_IDLE;
				end
				default: state_reg <= aal_pkg::ST_IDLE;
			endcase
		end
	end

endmodule : aal_datapath

// [dv/aal_datapath_monitor.sv]
// Bus timing and register read-back checks for the datapath
`timescale 1ns/1ps
module aal_datapath_monitor (
	// Clock and reset
	input wire logic        hclk,
	input wire logic        hresetn,
	// Bus request
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	// Bus answer
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Accepted address phases
	wire logic go = hsel && hready && htrans[1];
	wire logic rgo = go && !hwrite;

	property p_okay; hresp == 1'b0; endproperty
	a_okay: assert property (p_okay)
		else $error("Response not OKAY");
	property p_rwait; rgo |-> ##1 !hreadyout ##1 hreadyout; endproperty
	a_rwait: assert property (p_rwait)
		else $error("Read wait state wrong");
	property p_wnow; go && hwrite |=> hreadyout; endproperty
	a_wnow: assert property (p_wnow)
		else $error("Write stalled");
	property p_sec; rgo && haddr[7:0] == 8'hf0 |-> ##2 hrdata[31:8] == 0;
	endproperty
	a_sec: assert property (p_sec)
		else $error("Second operand read too wide");
	property p_acc; rgo && haddr[7:0] == 8'h00 |-> ##2 hrdata[31:8] == 0;
	endproperty
	a_acc: assert property (p_acc)
		else $error("Work register read too wide");
	property p_flg; rgo && haddr[7:0] == 8'h04 |->
		##2 (hrdata & 32'hffffff3b) == 0; endproperty
	a_flg: assert property (p_flg)
		else $error("Flag read has stray bits");
	property p_cmd; rgo && haddr[7:0] == 8'h0c |-> ##2 hrdata == 0;
	endproperty
	a_cmd: assert property (p_cmd)
		else $error("Command read not zero");
	property p_hole; rgo && haddr[7:0] == 8'h18 |-> ##2 hrdata == 0;
	endproperty
	a_hole: assert property (p_hole)
		else $error("Unmapped read not zero");
endmodule : aal_datapath_monitor

bind aal_datapath aal_datapath_monitor u_mon (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// [dv/aal_seq_model.sv]
// Bus master standing in for the instruction sequencer
`timescale 1ns/1ps
module aal_seq_model (
	// Clock and bus answer
	input  wire logic        hclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// Bus request
	output logic             hsel,
	output logic      [31:0] haddr,
	output logic      [1:0]  htrans,
	output logic             hwrite,
	output logic      [2:0]  hsize,
	output logic      [31:0] hwdata
);
	// Idle bus at time zero
	initial
	begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
	end

	// Address phase held until hready; stale data inverted
	task automatic aph(input logic [7:0] a, input logic w);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= w;
		hwdata <= ~hwdata;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'b00;
	endtask : aph

	// Single word write
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		aph(a, 1'b1);
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
	endtask : wr

	// Single word read, data taken at the ready edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		aph(a, 1'b0);
		do @(posedge hclk); while (hready !== 1'b1);
		d = hrdata;
	endtask : rd
endmodule : aal_seq_model

// [dv/accumulator_alu_mul_div_rotate_logic_tb_top.sv]
// Self-checking bench for the accumulator datapath
`timescale 1ns/1ps
module accumulator_alu_mul_div_rotate_logic_tb_top;
	// Clock, reset and bus nets
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	// Counters and read buffer
	int          bad_count;
	int          n_tests;
	int          cyc;
	logic [31:0] rv;

	aal_datapath u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp));
	aal_seq_model u_bus (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata));

	// Clock
	always #5 hclk = ~hclk;

	// Hang guard
	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			$display("Error %0t: run timed out", $time);
			bad_count++;
			summarize();
		end
	end

	// Flag word: carry, half carry set, range
	function automatic logic [31:0] fl(input logic c, input logic r);
		return {24'h0, c, 1'b1, 3'h0, r, 2'b00};
	endfunction : fl

	// Read and compare
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		u_bus.rd(a, rv);
		n_tests++;
		if (rv !== e)
		begin
			$display("Error %0t: reg %h got %h exp %h", $time, a, rv, e);
			bad_count++;
		end
	endtask : rchk

	// Command write
	task automatic cmd(input logic [3:0] op, input logic dr,
		input logic si, input logic [2:0] bs);
		u_bus.wr(8'h0c, {21'h0, bs, 2'b00, si, dr, op});
	endtask : cmd

	// Reset values, unmapped place, second operand
	task automatic t_regs();
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		rchk(8'h08, 32'h0);
		rchk(8'h10, 32'h0);
		rchk(8'h14, 32'h0);
		rchk(8'hf0, 32'h0);
		u_bus.wr(8'h18, 32'h5a5a5a5a);
		rchk(8'h18, 32'h0);
		rchk(8'h0c, 32'h0);
	endtask : t_regs

	// Product table
	task automatic t_mul();
		logic [7:0]  x [3] = '{8'h20, 8'h0f, 8'hff};
		logic [7:0]  y [3] = '{8'h75, 8'h11, 8'hff};
		logic [15:0] p;
		for (int i = 0; i < 3; i++)
		begin
			p = x[i] * y[i];
			u_bus.wr(8'h00, {24'h0, x[i]});
			u_bus.wr(8'hf0, {24'h0, y[i]});
			u_bus.wr(8'h04, fl(1'b1, 1'b1));
			cmd(aal_pkg::OP_PRODUCT, 1'b0, 1'b0, 3'h0);
			rchk(8'h00, {24'h0, p[7:0]});
			rchk(8'hf0, {24'h0, p[15:8]});
			rchk(8'h04, fl(1'b0, p > 16'h00ff));
		end
	endtask : t_mul

	// Quotient table, then zero divisor
	task automatic t_div();
		logic [7:0] x [2] = '{8'hf3, 8'h07};
		logic [7:0] y [2] = '{8'h13, 8'h09};
		for (int i = 0; i < 2; i++)
		begin
			u_bus.wr(8'h00, {24'h0, x[i]});
			u_bus.wr(8'hf0, {24'h0, y[i]});
			u_bus.wr(8'h04, fl(1'b1, 1'b1));
			cmd(aal_pkg::OP_QUOTIENT, 1'b0, 1'b0, 3'h0);
			// Command while busy must be ignored
			cmd(aal_pkg::OP_RR, 1'b0, 1'b0, 3'h0);
			rchk(8'h14, 32'h1);
			rv = 32'h1;
			for (int n = 0; n < 20 && rv[0] !== 1'b0; n++)
				u_bus.rd(8'h14, rv);
			rchk(8'h00, {24'h0, x[i] / y[i]});
			rchk(8'hf0, {24'h0, x[i] % y[i]});
			rchk(8'h04, fl(1'b0, 1'b0));
		end
		u_bus.wr(8'hf0, 32'h0);
		u_bus.wr(8'h04, fl(1'b1, 1'b0));
		cmd(aal_pkg::OP_QUOTIENT, 1'b0, 1'b0, 3'h0);
		rchk(8'h04, fl(1'b0, 1'b1));
		rchk(8'h14, 32'h2);
	endtask : t_div

	// Four rotates, both carry values, two patterns
	task automatic t_rot();
		logic [7:0] a;
		logic [7:0] e;
		logic       c;
		logic       ec;
		for (int k = 0; k < 16; k++)
		begin
			a = k[3] ? 8'h81 : 8'h4e;
			c = k[2];
			e = k[1] ? {a[6:0], k[0] ? c : a[7]} : {k[0] ? c : a[0], a[7:1]};
			ec = k[0] ? (k[1] ? a[7] : a[0]) : c;
			u_bus.wr(8'h00, {24'h0, a});
			u_bus.wr(8'h04, fl(c, 1'b1));
			cmd(4'h3 + k[1:0], 1'b0, 1'b0, 3'h0);
			if (k[1])
				rchk(8'h00, {24'h0, e});
			else
				rchk(8'h00, {24'h0, e});
			rchk(8'h04, fl(ec, 1'b1));
		end
	endtask : t_rot

	// Byte logic over every destination and source
	task automatic t_logic();
		logic [7:0] f;
		logic [7:0] s;
		logic [7:0] r;
		logic [7:0] ea;
		u_bus.wr(8'h04, fl(1'b1, 1'b1));
		u_bus.wr(8'h08, 32'h35a6);
		for (int k = 0; k < 12; k++)
		begin
			f = k[0] ? 8'ha6 : 8'h5c;
			s = k[1] ? 8'h35 : 8'h5c;
			r = k[3:2] == 0 ? f & s : k[3:2] == 1 ? f | s : f ^ s;
			u_bus.wr(8'h00, 32'h5c);
			cmd(4'h7 + k[3:2], k[0], k[1], 3'h0);
			ea = k[0] ? 8'h5c : r;
			rchk(8'h00, {24'h0, ea});
			if (k[0])
				rchk(8'h10, {24'h0, r});
		end
		rchk(8'h04, fl(1'b1, 1'b1));
	endtask : t_logic

	// Carry with bit, each form and the empty slot after them
	task automatic t_carry();
		logic [7:0] o;
		logic       c;
		logic       b;
		logic       ec;
		for (int k = 0; k < 20; k++)
		begin
			c = k[0];
			b = k[1];
			o = b ? 8'h08 : 8'hf7;
			ec = k[4:2] == 0 ? c & b : k[4:2] == 1 ? c & ~b :
				k[4:2] == 2 ? c | b : k[4:2] == 3 ? c | ~b : c;
			u_bus.wr(8'h08, {24'h0, o});
			u_bus.wr(8'h04, fl(c, 1'b1));
			cmd(4'ha + k[4:2], 1'b0, 1'b0, 3'h3);
			if (k < 8)
				rchk(8'h04, fl(ec, 1'b1));
			else
				rchk(8'h04, fl(ec, 1'b1));
			rchk(8'h08, {24'h0, o});
		end
	endtask : t_carry

	// Reset in mid-run; acc, flags, second and result read back as zero
	task automatic t_rst();
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rchk(8'h00, 32'h0);
		rchk(8'h04, 32'h0);
		rchk(8'hf0, 32'h0);
		rchk(8'h10, 32'h0);
	endtask : t_rst

	// Counts and verdict
	task automatic summarize();
		$display("Checks %0d, errors %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : summarize

	// Main sequence
	initial
	begin
		hclk = 1'b0;
		hresetn = 1'b0;
		bad_count = 0;
		n_tests = 0;
		cyc = 0;
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_mul();
		t_div();
		t_rot();
		t_logic();
		t_carry();
		t_rst();
		summarize();
	end
endmodule : accumulator_alu_mul_div_rotate_logic_tb_top
